/* File: hw/odt_timer.v */
`include "odt_map.vh"

module odt_timer #(
  parameter [7:0] OSC_HALF = 8'h01
) (
  input wire CORE_CLK,
  input wire RST,
  input wire OSC_ENABLE_CFG,
  input wire RATIO_VALID_CFG,
  input wire [1:0] RATIO_SEL_CFG,
  input wire OSC_FEEDBACK_SEL_CFG,
  input wire DIVIDER_FEEDBACK_SEL_CFG,
  input wire OSC_CELL_FEEDBACK,
  input wire DIVIDER_CELL_FEEDBACK,
  input wire DIVIDER_RESET_IN,
  input wire OSC_DYNAMIC_DISABLE,
  output wire OSC_CLOCK_OUT,
  output reg DIVIDED_CLOCK_OUT,
  output reg OSC_FEEDBACK_CELL,
  output reg DIVIDER_FEEDBACK_CELL
);
  // Half of the ratio, as the terminal count of the chain
  function [19:0] half_count;
    input [1:0] sel;
    begin
      case (sel)
        `ODT_SEL_1024: half_count = `ODT_HALF_1024;
        `ODT_SEL_1M: half_count = `ODT_HALF_1M;
        default: half_count = `ODT_HALF_128;
      endcase
    end
  endfunction

  // Terminal test for the chain at the selected ratio
  function at_terminal;
    input [19:0] count;
    input [1:0] code;
    begin
      at_terminal = (count >= half_count(code) - `ODT_CNT_ONE);
    end
  endfunction

  // Feedback select: block output or the cell's own feedback
  function fb_pick;
    input use_block;
    input block_val;
    input cell_val;
    begin
      if (use_block) begin
        fb_pick = block_val;
      end else begin
        fb_pick = cell_val;
      end
    end
  endfunction

  // Divider control: off while the oscillator is stopped, held while
  // the reset input was high at the last oscillator rise, else running
  localparam [2:0] ST_OFF = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  wire [1:0] sel;
  wire osc_run;
  wire osc_rise;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  wire div_hold;
  reg [19:0] cnt_reg;
  reg [19:0] cnt_next;
  reg div_next;

  assign sel = RATIO_VALID_CFG ? RATIO_SEL_CFG : `ODT_SEL_DEFAULT;
  assign osc_run = OSC_ENABLE_CFG & ~OSC_DYNAMIC_DISABLE;

  odt_osc #(.OSC_HALF(OSC_HALF)) odt_osc_i (
    .clk(CORE_CLK),
    .rst(RST),
    .run(osc_run),
    .osc(OSC_CLOCK_OUT),
    .osc_rise(osc_rise)
  );

  // Reset stage advances only on oscillator rises, apart from the drop to ST_OFF when the oscillator stops; a reset input that
  // moves between rises is seen late, so fabric should drive it in
  // step with the oscillator
  always @* begin
    state_next = state_reg;
    if (!osc_run) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF, ST_HOLD: begin
          if (osc_rise && !DIVIDER_RESET_IN) begin
            state_next = ST_RUN;
          end else if (osc_rise) begin
            state_next = ST_HOLD;
          end
        end
        ST_RUN: begin
          if (osc_rise && DIVIDER_RESET_IN) begin
            state_next = ST_HOLD;
          end
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign div_hold = (state_reg != ST_RUN);

  always @* begin
    cnt_next = cnt_reg;
    div_next = DIVIDED_CLOCK_OUT;
    if (div_hold) begin
      cnt_next = `ODT_CNT_ZERO;
      div_next = 1'b0;
    end else if (osc_rise) begin
      if (at_terminal(cnt_reg, sel)) begin
        cnt_next = `ODT_CNT_ZERO;
        div_next = ~DIVIDED_CLOCK_OUT;
      end else begin
        cnt_next = cnt_reg + `ODT_CNT_ONE;
      end
    end
  end

  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= `ODT_CNT_ZERO;
      DIVIDED_CLOCK_OUT <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      DIVIDED_CLOCK_OUT <= div_next;
    end
  end

  // Global routing: block outputs may replace the cell feedback
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      OSC_FEEDBACK_CELL <= 1'b0;
      DIVIDER_FEEDBACK_CELL <= 1'b0;
    end else begin
      OSC_FEEDBACK_CELL <= fb_pick(OSC_FEEDBACK_SEL_CFG, OSC_CLOCK_OUT,
        OSC_CELL_FEEDBACK);
      DIVIDER_FEEDBACK_CELL <= fb_pick(DIVIDER_FEEDBACK_SEL_CFG,
        DIVIDED_CLOCK_OUT, DIVIDER_CELL_FEEDBACK);
    end
  end
endmodule

/* File: hw/odt_map.vh */
`ifndef ODT_MAP_VH
`define ODT_MAP_VH

// Ratio selection codes
`define ODT_SEL_W 2
`define ODT_SEL_128 2'h0
`define ODT_SEL_1024 2'h1
`define ODT_SEL_1M 2'h2
`define ODT_SEL_DEFAULT 2'h0

// Divider chain lengths for each ratio
`define ODT_BITS_128 7
`define ODT_BITS_1024 10
`define ODT_BITS_1M 20
`define ODT_CNT_W 20

// Half ratios, the terminal counts of the chain
`define ODT_HALF_128 20'h00040
`define ODT_HALF_1024 20'h00200
`define ODT_HALF_1M 20'h80000
`define ODT_CNT_ONE 20'h00001
`define ODT_CNT_ZERO 20'h00000

// Nominal oscillator frequency in kHz
`define ODT_OSC_KHZ 5000

`endif

/* File: hw/odt_osc.v */
// Oscillator model: toggles every OSC_HALF core cycles while running.
// Stops at low when disabled so no edges reach the divider.
module odt_osc #(
  parameter [7:0] OSC_HALF = 8'h01
) (
  input wire clk,
  input wire rst,
  input wire run,
  output reg osc,
  output reg osc_rise
);
  reg [7:0] cnt_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      osc <= 1'b0;
      osc_rise <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 8'h00;
      osc <= 1'b0;
      osc_rise <= 1'b0;
    end else if (cnt_reg == OSC_HALF - 8'h01) begin
      cnt_reg <= 8'h00;
      osc <= ~osc;
      osc_rise <= ~osc;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      osc_rise <= 1'b0;
    end
  end
endmodule

/* File: test/odt_timer_props.sv */
module odt_props #(parameter [7:0] OSC_HALF = 8'h01) (
  input wire CORE_CLK, RST, OSC_ENABLE_CFG, RATIO_VALID_CFG,
  input wire [1:0] RATIO_SEL_CFG,
  input wire OSC_FEEDBACK_SEL_CFG, DIVIDER_FEEDBACK_SEL_CFG,
  input wire OSC_CELL_FEEDBACK, DIVIDER_CELL_FEEDBACK, DIVIDER_RESET_IN,
  input wire OSC_DYNAMIC_DISABLE, OSC_CLOCK_OUT, DIVIDED_CLOCK_OUT,
  input wire OSC_FEEDBACK_CELL, DIVIDER_FEEDBACK_CELL);
  timeunit 1ns;
  timeprecision 1ns;
  wire r128 = !RATIO_VALID_CFG || RATIO_SEL_CFG != 2'h1 && !RATIO_SEL_CFG[1];
  wire run = OSC_ENABLE_CFG && !OSC_DYNAMIC_DISABLE;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  osc_off_a: assert property (
    (!OSC_ENABLE_CFG)[*3] |-> !OSC_CLOCK_OUT) else $error("osc not off");
  dis_stop_a: assert property (
    OSC_DYNAMIC_DISABLE[*3] |-> !OSC_CLOCK_OUT && !DIVIDED_CLOCK_OUT)
    else $error("disable ignored");
  osc_run_a: assert property (
    run[*4] |-> OSC_HALF != 1 || $changed(OSC_CLOCK_OUT)) else $error("osc");
  div_hold_a: assert property (
    DIVIDER_RESET_IN[*4] |-> !DIVIDED_CLOCK_OUT) else $error("div reset");
  first_a: assert property (
    $fell(DIVIDER_RESET_IN) |-> !DIVIDED_CLOCK_OUT[*8]) else $error("early");
  half_a: assert property (
    $rose(DIVIDED_CLOCK_OUT) && r128 |-> ##127 DIVIDED_CLOCK_OUT
    ##1 !DIVIDED_CLOCK_OUT) else $error("half period");
  osc_fb_a: assert property (1 |=> OSC_FEEDBACK_CELL ==
    $past(OSC_FEEDBACK_SEL_CFG ? OSC_CLOCK_OUT : OSC_CELL_FEEDBACK))
    else $error("osc feedback");
  div_fb_a: assert property (1 |=> DIVIDER_FEEDBACK_CELL ==
    $past(DIVIDER_FEEDBACK_SEL_CFG ? DIVIDED_CLOCK_OUT : DIVIDER_CELL_FEEDBACK))
    else $error("div feedback");
endmodule
bind odt_timer odt_props #(.OSC_HALF(OSC_HALF)) odt_props_i (.*);

/* File: test/odt_fabric.sv */
module odt_fabric (
  input wire CORE_CLK, OSC_CLOCK_OUT, rst_req, dis_req,
  output reg DIVIDER_RESET_IN = 1'b1, OSC_DYNAMIC_DISABLE = 1'b0);
  timeunit 1ns;
  timeprecision 1ns;
  reg osc_q = 1'b0;
  // Reset cell moves only after an oscillator rise
  always @(posedge CORE_CLK) begin
    osc_q <= OSC_CLOCK_OUT;
    if (OSC_CLOCK_OUT && !osc_q) DIVIDER_RESET_IN <= #1 rst_req;
    OSC_DYNAMIC_DISABLE <= #1 dis_req;
  end
endmodule

/* File: test/odt_timer_tb.sv */
module odt_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg CORE_CLK = 0, RST = 1, OSC_ENABLE_CFG = 1, RATIO_VALID_CFG = 1;
  reg [1:0] RATIO_SEL_CFG = 2'h0;
  reg OSC_FEEDBACK_SEL_CFG = 0, DIVIDER_FEEDBACK_SEL_CFG = 0;
  reg OSC_CELL_FEEDBACK = 0, DIVIDER_CELL_FEEDBACK = 0, rst_req = 1, dis_req = 0;
  wire DIVIDER_RESET_IN, OSC_DYNAMIC_DISABLE, OSC_CLOCK_OUT;
  wire DIVIDED_CLOCK_OUT, OSC_FEEDBACK_CELL, DIVIDER_FEEDBACK_CELL;
  integer n_fail = 0, n_checks = 0, c;
  odt_timer odt_timer_i (.*);
  odt_fabric odt_fabric_i (.*);
  always #50 CORE_CLK = ~CORE_CLK;
  task cyc(input integer k);
    begin repeat (k) @(posedge CORE_CLK); #1; end
  endtask
  task chk(input string nm, input [31:0] e, s);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %0d seen %0d", nm, e, s);
      end
    end
  endtask
  // Count core cycles to first rise, then the high phase length
  task t_ratio(input v, input [1:0] s, input integer h);
    begin
      rst_req = 1; RATIO_VALID_CFG = v; RATIO_SEL_CFG = s; cyc(4);
      rst_req = 0; c = 0;
      while (DIVIDED_CLOCK_OUT !== 1'b1 && c < 3000) begin cyc(1); c = c + 1; end
      chk("first rise", 1, c >= h && c <= h + 10);
      c = 0;
      while (DIVIDED_CLOCK_OUT !== 1'b0 && c < 3000) begin cyc(1); c = c + 1; end
      chk("half period", h, c);
    end
  endtask
  task t_quiet(input en, dis);
    begin
      OSC_ENABLE_CFG = en; dis_req = dis; cyc(4);
      for (c = 0; c < 16; c = c + 1) begin
        chk("quiet", 0, {OSC_CLOCK_OUT, DIVIDED_CLOCK_OUT});
        cyc(1);
      end
      OSC_ENABLE_CFG = 1; dis_req = 0; cyc(4);
    end
  endtask
  task t_fb;
    begin
      OSC_CELL_FEEDBACK = 1;
      DIVIDER_CELL_FEEDBACK = 1;
      DIVIDER_FEEDBACK_SEL_CFG = 1;
      cyc(2);
      chk("osc cell", 1, OSC_FEEDBACK_CELL);
      chk("div out", 0, DIVIDED_CLOCK_OUT);
      chk("div fb", 0, DIVIDER_FEEDBACK_CELL);
      OSC_FEEDBACK_SEL_CFG = 1;
      cyc(2);
      repeat (4) begin
        c = OSC_CLOCK_OUT;
        cyc(1);
        chk("osc toggle", !c, OSC_CLOCK_OUT);
        chk("osc fb", c, OSC_FEEDBACK_CELL);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    cyc(2);
    RST = 0;
    t_ratio(0, 2'h2, 128);
    t_ratio(1, 2'h0, 128);
    t_ratio(1, 2'h1, 1024);
    t_ratio(1, 2'h3, 128);
    t_quiet(1, 1);
    t_quiet(0, 0);
    t_fb;
    stop_test;
  end
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    stop_test;
  end
endmodule
